// ---- bench/period_match_timer_sva.sv ----
`timescale 1ns/10ps
module period_match_timer_sva
	import period_match_timer_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_hsel,
	input wire logic [DATA_W-1:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [DATA_W-1:0] i_hwdata,
	input wire logic i_hready,
	input wire logic o_hreadyout,
	input wire logic [DATA_W-1:0] o_hrdata,
	input wire logic o_hresp,
	input wire logic [REG_W-1:0] o_pwm_count,
	input wire logic o_pwm_match
);
	// ----------------
	// Bus tracking
	// ----------------
	logic take;
	logic wr_q;
	logic on_q;
	logic [DATA_W-1:0] addr_q;
	assign take = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_q <= 1'b0;
			addr_q <= '0;
		end else begin
			wr_q <= take && i_hwrite;
			addr_q <= take ? i_haddr : addr_q;
		end
	end
	// Mirrors the run bit so a stopped timer can be judged
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			on_q <= 1'b0;
		end else if (wr_q && addr_q == {IDX_PERIOD_TIMER_CONTROL, 2'b00}) begin
			on_q <= i_hwdata[TIMER_ON_BIT];
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_one_wait;
		!o_hreadyout ##1 o_hreadyout;
	endsequence
	a_read_wait: assert property (take && !i_hwrite |=> s_one_wait)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && i_hwrite |=> o_hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (o_hresp == HRESP_OKAY)
		else $error("response not okay");
	a_rdata_upper: assert property (o_hrdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_match_zero: assert property (o_pwm_match |-> o_pwm_count == 8'h00)
		else $error("match without wrap");
	a_match_pulse: assert property (o_pwm_match |=> !o_pwm_match)
		else $error("match longer than one cycle");
	a_count_step: assert property ($changed(o_pwm_count) && !$past(wr_q) |->
		o_pwm_count == $past(o_pwm_count) + 8'h01 || o_pwm_count == 8'h00)
		else $error("count jumped");
	a_off_hold: assert property (!on_q && !wr_q |=> $stable(o_pwm_count))
		else $error("count moved while off");
endmodule

// ---- bench/period_match_timer_test.sv ----
`timescale 1ns/10ps
module period_match_timer_test
	import period_match_timer_pkg::*;
;
	logic i_core_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [1:0] i_htrans = 2'h0;
	logic i_hwrite = 1'b0;
	logic [DATA_W-1:0] i_haddr = '0;
	logic [DATA_W-1:0] i_hwdata = '0;
	logic o_hreadyout, o_hresp, o_irq, o_pwm_match;
	logic [DATA_W-1:0] o_hrdata;
	logic [REG_W-1:0] o_pwm_count;
	logic [DATA_W-1:0] exp_q[$];
	logic [31:0] seed = 32'h0000_02be;
	logic rd_p = 1'b0;
	logic seen;
	int error_cnt = 0;
	int comparisons = 0;
	int n;
	int m;
	int r;
	always #10 i_core_clk = ~i_core_clk;
	period_match_timer u_period_match_timer (.i_core_clk, .i_nrst, .i_hsel(1'b1), .i_haddr, .i_htrans,
		.i_hwrite, .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hrdata, .o_hresp,
		.o_irq, .o_pwm_count, .o_pwm_match);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ----------------
	// Bus and wait helpers
	// ----------------
	task wait_for(input int kind);
		n = 0;
		do begin
			@(negedge i_core_clk);
			seen = kind ? o_pwm_match : o_hreadyout;
			@(posedge i_core_clk);
			n++;
		end while (!seen && n < 2000);
		if (!seen) begin
			check(0, 1, "wait limit");
			tally_and_finish();
		end
	endtask
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		i_haddr <= a;
		i_hwrite <= w;
		i_htrans <= HTRANS_NONSEQ;
		wait_for(0);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		wait_for(0);
	endtask
	task rd(input logic [31:0] a, input logic [31:0] exp);
		exp_q.push_back(exp);
		xfer(1'b0, a, 32'h0);
	endtask
	// Read data is judged where it lands, against the oldest note
	always @(negedge i_core_clk) begin
		if (rd_p && o_hreadyout) begin
			check(o_hrdata, exp_q.pop_front(), "read data");
			rd_p = 1'b0;
		end
		if (i_htrans == HTRANS_NONSEQ && o_hreadyout && !i_hwrite) begin
			rd_p = 1'b1;
		end
	end
	initial begin
		repeat (16) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		@(posedge i_core_clk);
		rd(32'h0000_0248, 32'h0000_00ff);
		rd(32'h0000_0044, 32'h0000_0000);
		rd(32'h0000_0048, 32'h0000_0000);
		rd(32'h0000_0030, 32'h0000_0000);
		rd(32'h0000_0004, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			xfer(1'b1, 32'h0000_0248, seed);
			rd(32'h0000_0248, {24'h00_0000, seed[7:0]});
		end
		xfer(1'b1, 32'h0000_0048, 32'hffff_fffb);
		rd(32'h0000_0048, 32'h0000_007b);
		$display("test registers done");
		xfer(1'b1, 32'h0000_0248, 32'h0000_0002);
		for (int p = 0; p < 4; p++) begin
			r = (p == 0) ? 1 : (p == 1) ? 4 : 16;
			xfer(1'b1, 32'h0000_0048, 32'h4 | p);
			wait_for(1);
			wait_for(1);
			check(n, 12 * r, "match period");
		end
		$display("test prescale done");
		xfer(1'b1, 32'h0000_0230, 32'h0000_0002);
		for (int v = 0; v < 16; v += 5) begin
			xfer(1'b1, 32'h0000_0048, 32'h0);
			xfer(1'b1, 32'h0000_0030, 32'h0000_0002);
			repeat (2) @(negedge i_core_clk);
			check(o_irq, 0, "irq after clear");
			xfer(1'b1, 32'h0000_0048, 32'h4 | (v << 3));
			m = 0;
			for (int k = 0; k < 600 && !o_irq; k++) begin
				@(negedge i_core_clk);
				m += o_pwm_match;
			end
			check(m, v + 1, "matches per flag");
		end
		xfer(1'b1, 32'h0000_0230, 32'h0);
		xfer(1'b1, 32'h0000_0030, 32'h0000_0002);
		repeat (300) @(negedge i_core_clk);
		check(o_irq, 0, "masked irq");
		@(posedge i_core_clk);
		rd(32'h0000_0030, 32'h0000_0002);
		$display("test postscale done");
		xfer(1'b1, 32'h0000_0044, 32'h0000_0005);
		xfer(1'b1, 32'h0000_0048, 32'h0000_0078);
		rd(32'h0000_0044, 32'h0000_0005);
		repeat (40) @(posedge i_core_clk);
		rd(32'h0000_0044, 32'h0000_0005);
		$display("test hold done");
		tally_and_finish();
	end
endmodule
bind period_match_timer period_match_timer_sva u_sva (.i_core_clk, .i_nrst, .i_hsel, .i_haddr, .i_htrans,
	.i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hrdata, .o_hresp, .o_pwm_count, .o_pwm_match);

// ---- core/period_match_timer.sv ----
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
module period_match_timer
	import period_match_timer_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_hsel,
	input wire logic [DATA_W-1:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [DATA_W-1:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic [DATA_W-1:0] o_hrdata,
	output logic o_hresp,
	output logic o_irq,
	output logic [REG_W-1:0] o_pwm_count,
	output logic o_pwm_match
);

	// ---------------------------------------------------------------
	// Bus phase tracking
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WRITE = 4'b0010,
		ST_READ = 4'b0100,
		ST_RDONE = 4'b1000
	} bus_state_t;

	bus_state_t state_q;
	bus_state_t state_d;
	logic [IDX_W-1:0] idx_q;
	logic hit_q;
	logic accept;
	logic addr_ok;

	logic hreadyout_q;
	logic [DATA_W-1:0] hrdata_q;
	logic hresp_q;
	logic [DATA_W-1:0] read_value;

	logic [REG_W-1:0] flag_q;
	logic [REG_W-1:0] enable_q;
	logic [REG_W-1:0] control_q;
	logic [REG_W-1:0] count_q;
	logic [REG_W-1:0] limit_q;
	logic [3:0] post_q;
	logic match_q;
	logic irq_q;

	logic wr_now;
	logic wr_flag;
	logic wr_enable;
	logic wr_control;
	logic wr_count;
	logic wr_limit;
	logic clear_scalers;
	logic timer_on;
	logic tick;
	logic tick_ok;
	logic match;
	logic post_done;
	logic [REG_W-1:0] wdata;
	logic [3:0] postscale_select;
	logic [1:0] prescale_select;

	// Transfer size is not decoded: every register is one word and
	// only its low byte is kept.
	// Only word-aligned addresses inside the decoded window are mapped
	assign addr_ok = (i_haddr[DATA_W-1:ADDR_W] == '0) && (i_haddr[1:0] == 2'h0);
	assign accept = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);

	always_comb begin
		state_d = ST_IDLE;
		unique case (state_q)
			ST_IDLE, ST_WRITE, ST_RDONE: begin
				if (accept) begin
					state_d = i_hwrite ? ST_WRITE : ST_READ;
				end
			end
			ST_READ: begin
				state_d = ST_RDONE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Address and hit are held for the whole data phase
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			idx_q <= '0;
		end else if (accept && (state_q != ST_READ)) begin
			idx_q <= i_haddr[ADDR_W-1:2];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hit_q <= 1'b0;
		end else if (accept && (state_q != ST_READ)) begin
			hit_q <= addr_ok;
		end
	end

	// ---------------------------------------------------------------
	// Write strobes, applied at the end of the write data phase
	// ---------------------------------------------------------------
	assign wr_now = (state_q == ST_WRITE);
	assign wdata = i_hwdata[REG_W-1:0];

	// Writes outside the map fall to the default and are dropped
	always_comb begin
		wr_flag = 1'b0;
		wr_enable = 1'b0;
		wr_control = 1'b0;
		wr_count = 1'b0;
		wr_limit = 1'b0;
		if (wr_now && hit_q) begin
			unique case (idx_q)
				IDX_PERIPHERAL_FLAG: begin
					wr_flag = 1'b1;
				end
				IDX_PERIPHERAL_ENABLE: begin
					wr_enable = 1'b1;
				end
				IDX_PERIOD_TIMER_CONTROL: begin
					wr_control = 1'b1;
				end
				IDX_PERIOD_TIMER_COUNT: begin
					wr_count = 1'b1;
				end
				IDX_PERIOD_LIMIT: begin
					wr_limit = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Read data and response
	// ---------------------------------------------------------------
	// Reads take one wait state so that a write in the previous data
	// phase is already committed when the value is sampled.
	always_comb begin
		read_value = '0;
		if (hit_q) begin
			unique case (idx_q)
				IDX_PERIPHERAL_FLAG: read_value[REG_W-1:0] = flag_q;
				IDX_PERIPHERAL_ENABLE: read_value[REG_W-1:0] = enable_q;
				IDX_PERIOD_TIMER_CONTROL: read_value[REG_W-1:0] = control_q & CONTROL_MASK;
				IDX_PERIOD_TIMER_COUNT: read_value[REG_W-1:0] = count_q;
				IDX_PERIOD_LIMIT: read_value[REG_W-1:0] = limit_q;
				default: read_value = '0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hreadyout_q <= 1'b1;
		end else begin
			hreadyout_q <= (state_d != ST_READ);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hresp_q <= HRESP_OKAY;
		end else begin
			hresp_q <= HRESP_OKAY;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hrdata_q <= '0;
		end else if (state_q == ST_READ) begin
			hrdata_q <= read_value;
		end
	end

	// ---------------------------------------------------------------
	// Software-owned registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			limit_q <= RST_LIMIT;
		end else if (wr_limit) begin
			limit_q <= wdata;
		end
	end

	// Only the period-match enable is implemented; other bits stay zero
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			enable_q <= RST_ENABLE;
		end else if (wr_enable) begin
			enable_q <= wdata & (8'h01 << MATCH_FLAG_BIT);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			control_q <= RST_CONTROL;
		end else if (wr_control) begin
			control_q <= wdata & CONTROL_MASK;
		end
	end

	assign timer_on = control_q[TIMER_ON_BIT];
	assign prescale_select = control_q[PRESCALE_MSB:PRESCALE_LSB];
	assign postscale_select = control_q[POSTSCALE_MSB:POSTSCALE_LSB];
	assign clear_scalers = wr_count || wr_control;

	// ---------------------------------------------------------------
	// Prescaler
	// ---------------------------------------------------------------
	tick_prescaler u_prescaler (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_run(timer_on),
		.i_clear(clear_scalers),
		.i_prescale_select(prescale_select),
		.o_tick(tick)
	);

	// A tick already pending is dropped by a count or control write or by stopping,
	// so nothing advances after the timer is switched off.
	assign tick_ok = tick && timer_on && !clear_scalers;

	// ---------------------------------------------------------------
	// Counter
	// ---------------------------------------------------------------
	// A limit written below the running count is only met after the
	// count has run on through 8'hff and wrapped.
	assign match = tick_ok && (count_q == limit_q);

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			count_q <= RST_COUNT;
		end else if (wr_count) begin
			count_q <= wdata;
		end else if (match) begin
			count_q <= '0;
		end else if (tick_ok) begin
			count_q <= count_q + 8'h01;
		end
	end
	// A control write reaches count_q above only by dropping a pending tick through tick_ok.

	// ---------------------------------------------------------------
	// Postscaler
	// ---------------------------------------------------------------
	assign post_done = match && (post_q == postscale_select);

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			post_q <= '0;
		end else if (clear_scalers) begin
			post_q <= '0;
		end else if (post_done) begin
			post_q <= '0;
		end else if (match) begin
			post_q <= post_q + 4'h1;
		end
	end

	// ---------------------------------------------------------------
	// Flag and interrupt
	// ---------------------------------------------------------------
	// Write one to clear; a completion in the same cycle wins.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			flag_q <= RST_FLAG;
		end else if (post_done) begin
			flag_q[MATCH_FLAG_BIT] <= 1'b1;
		end else if (wr_flag && wdata[MATCH_FLAG_BIT]) begin
			flag_q[MATCH_FLAG_BIT] <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt output, one cycle behind the flag
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(flag_q & enable_q);
		end
	end

	// ---------------------------------------------------------------
	// Time base towards the PWM unit
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match;
		end
	end

	// ---------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ---------------------------------------------------------------
	assign o_hreadyout = hreadyout_q;
	assign o_hrdata = hrdata_q;
	assign o_hresp = hresp_q;
	assign o_irq = irq_q;
	assign o_pwm_count = count_q;
	assign o_pwm_match = match_q;

endmodule

// ---- core/period_match_timer_pkg.sv ----
// ---------------------------------------------------------------
// Shared constants of the period match timer
// ---------------------------------------------------------------
package period_match_timer_pkg;

	// ---------------------------------------------------------------
	// Bus geometry
	// ---------------------------------------------------------------
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W = 8;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned IDX_W = ADDR_W - 2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	// ---------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ---------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_PERIPHERAL_FLAG = 10'h00c;
	localparam logic [IDX_W-1:0] IDX_PERIOD_TIMER_COUNT = 10'h011;
	localparam logic [IDX_W-1:0] IDX_PERIOD_TIMER_CONTROL = 10'h012;
	localparam logic [IDX_W-1:0] IDX_PERIPHERAL_ENABLE = 10'h08c;
	localparam logic [IDX_W-1:0] IDX_PERIOD_LIMIT = 10'h092;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int unsigned PRESCALE_LSB = 0;
	localparam int unsigned PRESCALE_MSB = 1;
	localparam int unsigned TIMER_ON_BIT = 2;
	localparam int unsigned POSTSCALE_LSB = 3;
	localparam int unsigned POSTSCALE_MSB = 6;
	localparam logic [REG_W-1:0] CONTROL_MASK = 8'h7f;
	localparam int unsigned MATCH_FLAG_BIT = 1;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [REG_W-1:0] RST_FLAG = 8'h00;
	localparam logic [REG_W-1:0] RST_COUNT = 8'h00;
	localparam logic [REG_W-1:0] RST_CONTROL = 8'h00;
	localparam logic [REG_W-1:0] RST_ENABLE = 8'h00;
	localparam logic [REG_W-1:0] RST_LIMIT = 8'hff;

	// ---------------------------------------------------------------
	// Timing: core cycles per instruction tick and prescale ends
	// ---------------------------------------------------------------
	localparam int unsigned PRE_W = 6;
	localparam logic [PRE_W-1:0] TERM_DIV1 = 6'h03;
	localparam logic [PRE_W-1:0] TERM_DIV4 = 6'h0f;
	localparam logic [PRE_W-1:0] TERM_DIV16 = 6'h3f;

	// Last core-cycle count of one counter tick for a prescale code
	function automatic logic [PRE_W-1:0] prescale_terminal(input logic [1:0] sel);
		logic [PRE_W-1:0] t;
		t = TERM_DIV16;
		if (sel == 2'h0) begin
			t = TERM_DIV1;
		end else if (sel == 2'h1) begin
			t = TERM_DIV4;
		end
		return t;
	endfunction

endpackage

// ---- core/tick_prescaler.sv ----
`timescale 1ns/10ps
module tick_prescaler
	import period_match_timer_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_run,
	input wire logic i_clear,
	input wire logic [1:0] i_prescale_select,
	output logic o_tick
);

	logic [PRE_W-1:0] div_q;
	logic tick_q;

	// ---------------------------------------------------------------
	// Core clock divided by four, then by the prescale ratio
	// ---------------------------------------------------------------
	// One counter covers both stages, so a clear restarts the whole
	// instruction-rate phase as well as the prescaler.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			div_q <= '0;
		end else if (i_clear) begin
			div_q <= '0;
		end else if (i_run) begin
			if (div_q >= prescale_terminal(i_prescale_select)) begin
				div_q <= '0;
			end else begin
				div_q <= div_q + 6'h01;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= i_run && !i_clear && (div_q >= prescale_terminal(i_prescale_select));
		end
	end

	assign o_tick = tick_q;

endmodule
